// file: src/smel_defs.svh
// Constants for the signal and mailbox event logic.
// Assumes one 32-bit data path and four event sources.
`ifndef SMEL_DEFS_SVH
`define SMEL_DEFS_SVH
`define SMEL_DATA_W 32
`define SMEL_NUM_EV 4
`define SMEL_EV_SIG1 0
`define SMEL_EV_SIG2 1
`define SMEL_EV_OUTBOX 2
`define SMEL_EV_IRQ_OUTBOX 3
`define SMEL_SIG_RESET 32'h0000_0000
`define SMEL_MASK_RESET 4'h0
`endif

// file: src/smel_pkg.sv
// Types for the signal and mailbox event logic.
// Assumes smel_defs.svh is on the include path.
`include "smel_defs.svh"
package smel_pkg;
  typedef logic [`SMEL_DATA_W-1:0] smel_word_t;
  typedef logic [`SMEL_NUM_EV-1:0] smel_ev_t;
  typedef enum logic [2:0] {
    SMEL_IDLE = 3'b001,
    SMEL_SERVICE = 3'b010,
    SMEL_RESTORE = 3'b100
  } smel_hstate_t;
endpackage

// file: src/smel_if.sv
// Interface joining the event logic and the local handler.
// Assumes one shared clock; no clocking block.
`timescale 1ns/1ns
interface smel_if
  import smel_pkg::*;
(
  input wire logic clk_sys
);
  smel_ev_t mask_wr;
  logic mask_we;
  smel_ev_t mask_rd;
  smel_ev_t ack;
  logic ack_we;
  smel_ev_t pending;
  logic [3:0] count;
  logic sig1_re;
  logic sig2_re;
  smel_word_t sig1_data;
  smel_word_t sig2_data;
  logic obox_we;
  logic iobox_we;
  smel_word_t obox_wdata;
  modport dev (
    input mask_wr, mask_we, ack, ack_we, sig1_re, sig2_re,
    input obox_we, iobox_we, obox_wdata,
    output mask_rd, pending, count, sig1_data, sig2_data
  );
  modport hnd (
    output mask_wr, mask_we, ack, ack_we, sig1_re, sig2_re,
    output obox_we, iobox_we, obox_wdata,
    input mask_rd, pending, count, sig1_data, sig2_data
  );
endinterface

// file: src/smel_device.sv
// Event logic: signal registers, outbound mailboxes, mask and acks.
// Assumes outside writers and readers are synchronous to clk_sys.
`timescale 1ns/1ns
`include "smel_defs.svh"
module smel_device
  import smel_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  smel_if.dev loc,
  input wire logic sig1_we,
  input wire logic sig2_we,
  input wire smel_word_t sig_wdata,
  input wire logic obox_re,
  input wire logic iobox_re,
  output smel_word_t obox_rdata,
  output smel_word_t iobox_rdata,
  output logic obox_full,
  output logic iobox_full
);
  smel_word_t sig1;
  smel_word_t sig2;
  logic sig1_full;
  logic sig2_full;
  smel_ev_t mask;
  smel_ev_t pend;
  smel_ev_t cnt;
  smel_ev_t cnt_q;
  smel_ev_t rise;

  ////////////////////////////////////////////////////////////////////////
  // Overwrite on write; only empty-to-full raises
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sig1 <= `SMEL_SIG_RESET;
      sig1_full <= 1'b0;
    end else if (clk_en) begin
      if (loc.sig1_re && sig1_full) begin
        sig1 <= `SMEL_SIG_RESET;
        sig1_full <= 1'b0;
      end
      // A write in the read cycle wins, but it raises no event because full stays set
      if (sig1_we) begin
        sig1 <= sig_wdata;
        sig1_full <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sig2 <= `SMEL_SIG_RESET;
      sig2_full <= 1'b0;
    end else if (clk_en) begin
      if (loc.sig2_re && sig2_full) begin
        sig2 <= `SMEL_SIG_RESET;
        sig2_full <= 1'b0;
      end
      if (sig2_we) begin
        sig2 <= sig_wdata;
        sig2_full <= 1'b1;
      end
    end
  end

  assign loc.sig1_data = sig1;
  assign loc.sig2_data = sig2;

  ////////////////////////////////////////////////////////////////////////
  // One-deep outbound mailboxes
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      obox_rdata <= `SMEL_SIG_RESET;
      obox_full <= 1'b0;
    end else if (clk_en) begin
      if (obox_re && obox_full) begin
        obox_full <= 1'b0;
      end
      // Write while full is stalled: dropped here
      if (loc.obox_we && !obox_full) begin
        obox_rdata <= loc.obox_wdata;
        obox_full <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      iobox_rdata <= `SMEL_SIG_RESET;
      iobox_full <= 1'b0;
    end else if (clk_en) begin
      // outside read frees the irq mailbox
      if (iobox_re && iobox_full) begin
        iobox_full <= 1'b0;
      end
      if (loc.iobox_we && !iobox_full) begin
        iobox_rdata <= loc.obox_wdata;
        iobox_full <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counts as seen by the handler
  always_comb begin
    cnt = '0;
    cnt[`SMEL_EV_SIG1] = sig1_full;
    cnt[`SMEL_EV_SIG2] = sig2_full;
    cnt[`SMEL_EV_OUTBOX] = !obox_full;
    cnt[`SMEL_EV_IRQ_OUTBOX] = !iobox_full;
  end
  assign loc.count = cnt;
  assign rise = cnt & ~cnt_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      // Empty mailboxes at reset raise a free event
      // Otherwise nothing would ever fill them
      cnt_q <= 4'h0;
    end else if (clk_en) begin
      cnt_q <= cnt;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mask <= `SMEL_MASK_RESET;
    end else if (clk_en && loc.mask_we) begin
      mask <= loc.mask_wr;
    end
  end
  assign loc.mask_rd = mask;

  // set on rise wins over ack
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pend <= '0;
    end else if (clk_en) begin
      pend <= (pend & ~(loc.ack_we ? loc.ack : 4'h0)) | rise;
    end
  end
  assign loc.pending = pend & mask;
endmodule // smel_device

// file: src/smel_handler.sv
// Local handler: services all taken masked events per pass, at most one signal.
// Assumes the device answers within the same cycle on counts.
`timescale 1ns/1ns
`include "smel_defs.svh"
module smel_handler
  import smel_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  smel_if.hnd loc,
  input wire smel_ev_t enable,
  input wire smel_word_t next_word,
  output smel_word_t sig_value,
  output logic sig_valid,
  output logic [1:0] sig_src
);
  smel_hstate_t state;
  smel_ev_t saved;
  smel_ev_t work;
  smel_ev_t take;

  // One signal per pass: sig_value holds a single word
  function automatic smel_ev_t pick_events(input smel_ev_t t);
    smel_ev_t p;
    p = t;
    if (t[`SMEL_EV_SIG1]) begin
      p[`SMEL_EV_SIG2] = 1'b0;
    end
    return p;
  endfunction

  // Deferred second signal stays pending for the next pass
  assign take = pick_events(loc.pending & enable);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= SMEL_IDLE;
      saved <= '0;
      work <= '0;
    end else if (clk_en) begin
      unique case (state)
        SMEL_IDLE: begin
          // one mask write, one ack write
          if (|take) begin
            saved <= loc.mask_rd;
            work <= take;
            state <= SMEL_SERVICE;
          end
        end
        SMEL_SERVICE: begin
          state <= SMEL_RESTORE;
        end
        SMEL_RESTORE: begin
          state <= SMEL_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    loc.mask_we = 1'b0;
    loc.mask_wr = loc.mask_rd;
    loc.ack_we = 1'b0;
    loc.ack = '0;
    loc.sig1_re = 1'b0;
    loc.sig2_re = 1'b0;
    loc.obox_we = 1'b0;
    loc.iobox_we = 1'b0;
    loc.obox_wdata = next_word;
    if (state == SMEL_IDLE && |take && clk_en) begin
      loc.mask_we = 1'b1;
      loc.mask_wr = loc.mask_rd & ~take;
      loc.ack_we = 1'b1;
      loc.ack = take;
    end
    // Mask resets all off: open the handled events when idle
    if (state == SMEL_IDLE && !(|take) && clk_en
        && (loc.mask_rd & enable) != enable) begin
      loc.mask_we = 1'b1;
      loc.mask_wr = loc.mask_rd | enable;
    end
    if (state == SMEL_SERVICE) begin
      loc.sig1_re = work[`SMEL_EV_SIG1] && loc.count[`SMEL_EV_SIG1];
      loc.sig2_re = work[`SMEL_EV_SIG2] && loc.count[`SMEL_EV_SIG2]
        && !loc.sig1_re;
      loc.obox_we = work[`SMEL_EV_OUTBOX] && loc.count[`SMEL_EV_OUTBOX];
      loc.iobox_we = work[`SMEL_EV_IRQ_OUTBOX]
        && loc.count[`SMEL_EV_IRQ_OUTBOX];
    end
    if (state == SMEL_RESTORE) begin
      loc.mask_we = 1'b1;
      loc.mask_wr = saved;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sig_value <= '0;
      sig_valid <= 1'b0;
      sig_src <= 2'h0;
    end else if (clk_en) begin
      sig_valid <= loc.sig1_re | loc.sig2_re;
      if (loc.sig1_re) begin
        sig_value <= loc.sig1_data;
        sig_src <= 2'h1;
      end else if (loc.sig2_re) begin
        sig_value <= loc.sig2_data;
        sig_src <= 2'h2;
      end
    end
  end
endmodule // smel_handler

// file: sim/smel_properties.sv
// Checker for the local event handshake of the event logic.
// Assumes the interface signals plus the shared high reset.
`timescale 1ns/1ns
module smel_properties
  import smel_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire smel_ev_t mask_wr,
  input wire logic mask_we,
  input wire smel_ev_t mask_rd,
  input wire smel_ev_t ack,
  input wire logic ack_we,
  input wire smel_ev_t pending,
  input wire logic [3:0] count,
  input wire logic sig1_re,
  input wire logic sig2_re,
  input wire smel_word_t sig1_data,
  input wire smel_word_t sig2_data
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  a_sig1_clear: assert property (
    sig1_re && count[0] |=> !count[0] && sig1_data == '0)
    else $error("first signal not cleared");
  a_sig2_clear: assert property (
    sig2_re && count[1] |=> !count[1] && sig2_data == '0)
    else $error("second signal not cleared");
  a_sig1_pend: assert property (
    $rose(count[0]) && mask_rd[0] && !mask_we |=> pending[0])
    else $error("first signal event missing");
  a_sig2_pend: assert property (
    $rose(count[1]) && mask_rd[1] && !mask_we |=> pending[1])
    else $error("second signal event missing");
  a_ack_clear: assert property (
    ack_we && ack[0] && !$rose(count[0]) |=> !pending[0])
    else $error("ack left event pending");
  a_mask_gate: assert property ((pending & ~mask_rd) == '0)
    else $error("masked event reported");
  a_mask_write: assert property (
    mask_we |=> mask_rd == $past(mask_wr))
    else $error("mask write lost");
  a_mask_restore: assert property (
    mask_we && ack_we |-> ##2 mask_we && mask_wr == $past(mask_rd, 2))
    else $error("mask not restored");
  a_read_guard: assert property (
    (sig1_re -> count[0]) && (sig2_re -> count[1]))
    else $error("read with zero count");
  c_pend: cover property (pending[0]);
  c_read2: cover property (sig2_re);
  c_ack: cover property (mask_we && ack_we);
endmodule // smel_properties

// file: sim/tb.sv
// Bench joining event logic and handler through the interface.
// Assumes the handler enables its own mask bits when enabled.
`timescale 1ns/1ns
module tb;
  import smel_pkg::*;
  logic clk_sys = 0, rst = 1, sig1_we = 0, sig2_we = 0;
  logic obox_re = 0, iobox_re = 0, sig_valid, obox_full, iobox_full;
  smel_word_t sig_wdata = '0, next_word = '0, sig_value, v, w;
  smel_word_t obox_rdata, iobox_rdata;
  smel_ev_t enable = 4'hF;
  logic [1:0] sig_src;
  logic [33:0] exp_q[$], e;
  int n_fail = 0, total_checks = 0;
  always #50 clk_sys = ~clk_sys;
  smel_if i_smel_if (.clk_sys(clk_sys));
  smel_device i_smel_device (.clk_sys(clk_sys), .rst(rst), .clk_en(1'b1),
    .loc(i_smel_if), .sig1_we(sig1_we), .sig2_we(sig2_we),
    .sig_wdata(sig_wdata), .obox_re(obox_re), .iobox_re(iobox_re),
    .obox_rdata(obox_rdata), .iobox_rdata(iobox_rdata),
    .obox_full(obox_full),
    .iobox_full(iobox_full));
  smel_handler i_smel_handler (.clk_sys(clk_sys), .rst(rst),
    .clk_en(1'b1), .loc(i_smel_if), .enable(enable),
    .next_word(next_word), .sig_value(sig_value), .sig_valid(sig_valid),
    .sig_src(sig_src));
  smel_properties i_smel_properties (.clk_sys(clk_sys), .rst(rst),
    .mask_wr(i_smel_if.mask_wr), .mask_we(i_smel_if.mask_we),
    .mask_rd(i_smel_if.mask_rd), .ack(i_smel_if.ack),
    .ack_we(i_smel_if.ack_we), .pending(i_smel_if.pending),
    .count(i_smel_if.count), .sig1_re(i_smel_if.sig1_re),
    .sig2_re(i_smel_if.sig2_re), .sig1_data(i_smel_if.sig1_data),
    .sig2_data(i_smel_if.sig2_data));
  ////////////////////////////////////////
  task automatic check(input logic [33:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks=%0d fails=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic put_sig(input bit two, input smel_word_t d, input bit ex);
    @(negedge clk_sys);
    sig1_we = !two;
    sig2_we = two;
    sig_wdata = d;
    @(negedge clk_sys);
    sig1_we = 0;
    sig2_we = 0;
    if (ex) exp_q.push_back({two ? 2'h2 : 2'h1, d});
  endtask
  task automatic drain();
    for (int k = 0; k < 50 && exp_q.size() != 0; k++) @(negedge clk_sys);
    if (exp_q.size() != 0) begin
      n_fail++;
      finish_test();
    end
  endtask
  // Unexpected delivery compares against its own inverse
  always @(negedge clk_sys) begin
    if (!rst && sig_valid === 1'b1) begin
      e = exp_q.size() ? exp_q.pop_front() : ~{sig_src, sig_value};
      check({sig_src, sig_value}, e);
    end
  end
  initial begin
    v = $urandom(36632);
    next_word = $urandom();
    repeat (5) @(negedge clk_sys);
    rst = 0;
    for (int i = 0; i < 8; i++) begin
      put_sig(i[0], $urandom(), 1'b1);
      drain();
    end
    $display("signal test done");
    enable = 4'h0;
    v = $urandom();
    w = $urandom();
    put_sig(1'b0, v, 1'b0);
    put_sig(1'b1, w, 1'b0);
    repeat (20) @(negedge clk_sys);
    enable = 4'hF;
    exp_q.push_back({2'h1, v});
    exp_q.push_back({2'h2, w});
    drain();
    $display("masked event test done");
    check({32'h0, obox_full, iobox_full}, 34'h3);
    next_word = $urandom();
    obox_re = 1;
    iobox_re = 1;
    @(negedge clk_sys);
    obox_re = 0;
    iobox_re = 0;
    check({32'h0, obox_full, iobox_full}, 34'h0);
    for (int k = 0; k < 20 && !(obox_full && iobox_full); k++)
      @(negedge clk_sys);
    if (!(obox_full && iobox_full)) begin
      n_fail++;
      finish_test();
    end
    check({obox_rdata, obox_full, iobox_full}, {next_word, 2'b11});
    check({iobox_rdata, 2'b11}, {next_word, 2'b11});
    $display("mailbox test done");
    finish_test();
  end
endmodule // tb
